// ==== crc_pkg.sv ====
package crc_pkg;
    typedef logic [13:0] crc_addr_t;
    typedef logic [4:0]  crc_idx_t;
    typedef logic [7:0]  crc_byte_t;
    typedef logic [4:0]  crc_line_t;

    // ==========================================
    // register indices
    localparam crc_idx_t IDX_HTOT  = 5'h00;
    localparam crc_idx_t IDX_HDISP = 5'h01;
    localparam crc_idx_t IDX_VTOT  = 5'h04;
    localparam crc_idx_t IDX_VDISP = 5'h06;
    localparam crc_idx_t IDX_VSYNC = 5'h07;
    localparam crc_idx_t IDX_MODE  = 5'h08;
    localparam crc_idx_t IDX_SCAN  = 5'h09;
    localparam crc_idx_t IDX_CST   = 5'h0A;
    localparam crc_idx_t IDX_CEND  = 5'h0B;
    localparam crc_idx_t IDX_STH   = 5'h0C;
    localparam crc_idx_t IDX_STL   = 5'h0D;
    localparam crc_idx_t IDX_CURH  = 5'h0E;
    localparam crc_idx_t IDX_CURL  = 5'h0F;
    localparam crc_idx_t IDX_PENH  = 5'h10;
    localparam crc_idx_t IDX_PENL  = 5'h11;
    localparam crc_idx_t IDX_UPDH  = 5'h12;
    localparam crc_idx_t IDX_UPDL  = 5'h13;
    localparam crc_idx_t IDX_STAT  = 5'h14;
    localparam crc_idx_t IDX_IST   = 5'h15;
    localparam crc_idx_t IDX_IMSK  = 5'h16;
    localparam crc_idx_t IDX_DUMMY = 5'h1F;

    // ==========================================
    // field positions
    localparam int MODE_ROWCOL = 2;
    localparam int MODE_TRANSP = 3;
    localparam int MODE_DESKEW = 4;
    localparam int MODE_CSKEW  = 5;
    localparam int ST_UPD      = 7;
    localparam int ST_PEN      = 6;
    localparam int ST_VBLANK   = 5;
    localparam int IRQ_UPD     = 0;
    localparam int IRQ_PEN     = 1;
    localparam int IRQ_VBL     = 2;

    // ==========================================
    // values after reset
    localparam crc_byte_t HTOT_RST  = 8'h0F;
    localparam crc_byte_t HDISP_RST = 8'h0A;
    localparam logic [6:0] VTOT_RST  = 7'h07;
    localparam logic [6:0] VDISP_RST = 7'h06;
    localparam logic [6:0] VSYNC_RST = 7'h07;
    localparam crc_line_t SCAN_RST  = 5'h07;
    localparam crc_line_t CEND_RST  = 5'h07;
    localparam crc_addr_t ADDR_RST  = 14'h0000;

    // cursor modes
    typedef enum logic [1:0] {
        CUR_STEADY, CUR_NONE, CUR_BLINK16, CUR_BLINK32
    } crc_cmode_e;
endpackage

// ==== crc_core.sv ====
`timescale 1ns/1ps
// Functional notes
// R1: hold 7-bit displayed row count
// R2: vsync starts in programmed character row
// R3: hold 5-bit scan lines per row
// R4: 5-bit cursor first and last line
// R5: cursor mode steady, none, blink 16/32
// R6: 14-bit start address seeds display addresses
// R7: cursor when address matches inside lines
// R8: mode bit 5 delays cursor one character
// R9: pen rising edge captures address on fall
// R10: transparent update address auto increments
// R11: dummy location access counts as update
// R12: mode bit 2 selects binary or row/column
// R13: row/column puts column low, row high
// R14: outside logic arbitrates shared memory access
// R15: mode bit 4 delays display enable
// R16: status bit 5 shows vertical retrace
// R17: row scan counter restarts each row
module crc_core (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire crc_pkg::crc_idx_t reg_addr,
    input  wire crc_pkg::crc_byte_t reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output crc_pkg::crc_byte_t     reg_rdata,
    input  wire logic              character_clock,
    input  wire logic              light_pen_strobe,
    output crc_pkg::crc_addr_t     display_memory_address_lines,
    output crc_pkg::crc_line_t     row_scan_lines,
    output crc_pkg::crc_addr_t     update_address,
    output logic                   display_enable,
    output logic                   cursor,
    output logic                   vsync,
    output logic                   irq
);
    import crc_pkg::*;

    // ==========================================
    // programmed registers
    crc_byte_t  htot_q, hdisp_q, mode_q, rdata_q;
    logic [6:0] vtot_q, vdisp_q, vpos_q;
    crc_line_t  scan_q, cst_q, cend_q;
    crc_cmode_e cmode_q;
    crc_addr_t  start_q, curpos_q, pen_q, upd_q;
    logic [2:0] ist_q, imsk_q;
    logic       updrdy_q, penfull_q;

    // ==========================================
    // pin synchronisers and edges
    logic cc1_q, cc2_q, cc3_q, lp1_q, lp2_q, lp3_q;
    logic cc_tick, cc_fall, lp_rise, lp_pend_q, pen_cap;

    // ==========================================
    // raster state
    crc_byte_t  hcnt_q;
    crc_line_t  lcnt_q;
    logic [6:0] vrow_q;
    logic [4:0] fcnt_q;
    crc_addr_t  base_q, vaddr_d, vaddr_q;
    logic       line_end, row_end, frame_end, de_raw, vblank, vbl_q;
    logic       in_lines, blink_on, cur_raw;
    logic       cur_d1_q, de_d1_q, cursor_q, de_q, vsync_q;
    logic       acc_dummy, upd_evt;

    // two flops before any logic looks at the pins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cc1_q <= 1'b0;
            cc2_q <= 1'b0;
            cc3_q <= 1'b0;
            lp1_q <= 1'b0;
            lp2_q <= 1'b0;
            lp3_q <= 1'b0;
        end else begin
            cc1_q <= character_clock;
            cc2_q <= cc1_q;
            cc3_q <= cc2_q;
            lp1_q <= light_pen_strobe;
            lp2_q <= lp1_q;
            lp3_q <= lp2_q;
        end
    end

    assign cc_tick = cc2_q & ~cc3_q;
    assign cc_fall = ~cc2_q & cc3_q;
    assign lp_rise = lp2_q & ~lp3_q;
    assign pen_cap = (lp_pend_q | lp_rise) & cc_fall; // R9

    // host writes to the format registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            htot_q   <= HTOT_RST;
            hdisp_q  <= HDISP_RST;
            vtot_q   <= VTOT_RST;
            vdisp_q  <= VDISP_RST;
            vpos_q   <= VSYNC_RST;
            mode_q   <= 8'h00;
            scan_q   <= SCAN_RST;
            cst_q    <= 5'h00;
            cmode_q  <= CUR_STEADY;
            cend_q   <= CEND_RST;
            start_q  <= ADDR_RST;
            curpos_q <= ADDR_RST;
        end else if (reg_wr) begin
            if (reg_addr == IDX_HTOT) begin
                htot_q <= reg_wdata;
            end else if (reg_addr == IDX_HDISP) begin
                hdisp_q <= reg_wdata;
            end else if (reg_addr == IDX_VTOT) begin
                vtot_q <= reg_wdata[6:0];
            end else if (reg_addr == IDX_VDISP) begin
                vdisp_q <= reg_wdata[6:0]; // R1
            end else if (reg_addr == IDX_VSYNC) begin
                vpos_q <= reg_wdata[6:0]; // R2
            end else if (reg_addr == IDX_MODE) begin
                mode_q <= reg_wdata;
            end else if (reg_addr == IDX_SCAN) begin
                scan_q <= reg_wdata[4:0]; // R3
            end else if (reg_addr == IDX_CST) begin
                cst_q   <= reg_wdata[4:0]; // R4
                cmode_q <= crc_cmode_e'(reg_wdata[6:5]); // R5
            end else if (reg_addr == IDX_CEND) begin
                cend_q <= reg_wdata[4:0]; // R4
            end else if (reg_addr == IDX_STH) begin
                start_q[13:8] <= reg_wdata[5:0]; // R6
            end else if (reg_addr == IDX_STL) begin
                start_q[7:0] <= reg_wdata; // R6
            end else if (reg_addr == IDX_CURH) begin
                curpos_q[13:8] <= reg_wdata[5:0];
            end else if (reg_addr == IDX_CURL) begin
                curpos_q[7:0] <= reg_wdata;
            end
        end
    end

    // dummy location access in transparent mode
    assign acc_dummy = (reg_wr | reg_rd) && reg_addr == IDX_DUMMY;
    assign upd_evt   = acc_dummy & mode_q[MODE_TRANSP]; // R11

    // update address load and auto increment
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            upd_q <= ADDR_RST;
        end else if (reg_wr && reg_addr == IDX_UPDH) begin
            upd_q[13:8] <= reg_wdata[5:0];
        end else if (reg_wr && reg_addr == IDX_UPDL) begin
            upd_q[7:0] <= reg_wdata;
        end else if (upd_evt) begin
            upd_q <= upd_q + 14'h0001; // R10
        end
    end

    // update ready flag, set wins over clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            updrdy_q <= 1'b0;
        end else if (upd_evt) begin
            updrdy_q <= 1'b1; // R11
        end else if (reg_wr && (reg_addr == IDX_UPDH || reg_addr == IDX_UPDL)) begin
            updrdy_q <= 1'b0;
        end
    end

    // light pen pending edge and capture
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lp_pend_q <= 1'b0;
            pen_q     <= ADDR_RST;
            penfull_q <= 1'b0;
        end else begin
            if (pen_cap) begin
                lp_pend_q <= 1'b0;
            end else if (lp_rise) begin
                lp_pend_q <= 1'b1;
            end
            if (pen_cap) begin
                pen_q <= vaddr_q; // R9
            end
            if (pen_cap) begin
                penfull_q <= 1'b1;
            end else if (reg_rd && (reg_addr == IDX_PENH || reg_addr == IDX_PENL)) begin
                penfull_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // raster counters
    assign line_end  = hcnt_q == htot_q;
    assign row_end   = lcnt_q == scan_q;
    assign frame_end = vrow_q == vtot_q;
    assign vblank    = vrow_q >= vdisp_q; // R16
    assign de_raw    = hcnt_q < hdisp_q && !vblank; // R1

    // horizontal, scan line, row and field counts
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hcnt_q <= 8'h00;
            lcnt_q <= 5'h00;
            vrow_q <= 7'h00;
            fcnt_q <= 5'h00;
        end else if (cc_tick) begin
            if (!line_end) begin
                hcnt_q <= hcnt_q + 8'h01;
            end else begin
                hcnt_q <= 8'h00;
                if (!row_end) begin
                    lcnt_q <= lcnt_q + 5'h01; // R17
                end else begin
                    lcnt_q <= 5'h00; // R17
                    if (frame_end) begin
                        vrow_q <= 7'h00;
                        fcnt_q <= fcnt_q + 5'h01;
                    end else begin
                        vrow_q <= vrow_q + 7'h01;
                    end
                end
            end
        end
    end

    // row base for straight binary addressing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            base_q <= ADDR_RST;
        end else if (cc_tick && line_end && row_end) begin
            base_q <= frame_end ? start_q : base_q + {6'h00, hdisp_q}; // R6
        end
    end

    // address in the selected format
    always_comb begin
        if (mode_q[MODE_ROWCOL]) begin
            vaddr_d = {start_q[13:8] + vrow_q[5:0], start_q[7:0] + hcnt_q}; // R12 R13
        end else begin
            vaddr_d = base_q + {6'h00, hcnt_q}; // R12
        end
    end

    // ==========================================
    // cursor
    assign in_lines = lcnt_q >= cst_q && lcnt_q <= cend_q;

    // blink phase from the field counter
    always_comb begin
        case (cmode_q)
            CUR_STEADY:  blink_on = 1'b1; // R5
            CUR_NONE:    blink_on = 1'b0; // R5
            CUR_BLINK16: blink_on = fcnt_q[3]; // R5
            default:     blink_on = fcnt_q[4]; // R5
        endcase
    end

    assign cur_raw = vaddr_d == curpos_q && in_lines && blink_on; // R7

    // one character of skew for cursor and enable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur_d1_q <= 1'b0;
            de_d1_q  <= 1'b0;
        end else if (cc_tick) begin
            cur_d1_q <= cur_raw;
            de_d1_q  <= de_raw;
        end
    end

    // registered display outputs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            vaddr_q  <= ADDR_RST;
            cursor_q <= 1'b0;
            de_q     <= 1'b0;
            vsync_q  <= 1'b0;
            vbl_q    <= 1'b0;
        end else begin
            vaddr_q  <= vaddr_d;
            cursor_q <= mode_q[MODE_CSKEW] ? cur_d1_q : cur_raw; // R8
            de_q     <= mode_q[MODE_DESKEW] ? de_d1_q : de_raw; // R15
            vsync_q  <= vrow_q == vpos_q; // R2
            vbl_q    <= vblank;
        end
    end

    // ==========================================
    // interrupts: sticky, write one to clear, set wins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ist_q  <= 3'h0;
            imsk_q <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == IDX_IMSK) begin
                imsk_q <= reg_wdata[2:0];
            end
            ist_q <= (ist_q & ~((reg_wr && reg_addr == IDX_IST) ? reg_wdata[2:0] : 3'h0))
                   | {vblank & ~vbl_q, pen_cap, upd_evt};
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == IDX_CURH) begin
                rdata_q <= {2'b00, curpos_q[13:8]};
            end else if (reg_addr == IDX_CURL) begin
                rdata_q <= curpos_q[7:0];
            end else if (reg_addr == IDX_PENH) begin
                rdata_q <= {2'b00, pen_q[13:8]};
            end else if (reg_addr == IDX_PENL) begin
                rdata_q <= pen_q[7:0];
            end else if (reg_addr == IDX_STAT) begin
                rdata_q <= {updrdy_q, penfull_q, vblank, 5'h00}; // R16
            end else if (reg_addr == IDX_IST) begin
                rdata_q <= {5'h00, ist_q};
            end else if (reg_addr == IDX_IMSK) begin
                rdata_q <= {5'h00, imsk_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata                    = rdata_q;
    assign display_memory_address_lines = vaddr_q;
    assign row_scan_lines               = lcnt_q;
    assign update_address               = upd_q;
    assign display_enable               = de_q;
    assign cursor                       = cursor_q;
    assign vsync                        = vsync_q;
    assign irq                          = |(ist_q & imsk_q);

    // ==========================================
    // checks
    property p_de_rows;
        @(posedge mclk) disable iff (sys_rst)
        vrow_q >= vdisp_q && !mode_q[MODE_DESKEW] |=> !display_enable;
    endproperty
    a_de_rows: assert property (p_de_rows) else $error("enable in blank rows"); // R1

    property p_lcnt_wrap;
        @(posedge mclk) disable iff (sys_rst)
        cc_tick && line_end && row_end |=> row_scan_lines == 5'h00;
    endproperty
    a_lcnt_wrap: assert property (p_lcnt_wrap) else $error("scan count not restarted"); // R17

    property p_lcnt_step;
        @(posedge mclk) disable iff (sys_rst)
        cc_tick && line_end && !row_end |=> lcnt_q == $past(lcnt_q) + 5'h01;
    endproperty
    a_lcnt_step: assert property (p_lcnt_step) else $error("scan count not advanced"); // R3

    property p_no_cursor;
        @(posedge mclk) disable iff (sys_rst)
        cmode_q == CUR_NONE ##1 cmode_q == CUR_NONE ##1 cmode_q == CUR_NONE |-> !cursor;
    endproperty
    a_no_cursor: assert property (p_no_cursor) else $error("cursor in off mode"); // R5

    property p_cur_lines;
        @(posedge mclk) disable iff (sys_rst)
        cursor && !$past(mode_q[MODE_CSKEW]) |-> $past(in_lines && vaddr_d == curpos_q);
    endproperty
    a_cur_lines: assert property (p_cur_lines) else $error("cursor outside bounds"); // R7

    sequence s_skew_tick;
        cc_tick && mode_q[MODE_CSKEW] ##1 mode_q[MODE_CSKEW];
    endsequence
    property p_cur_skew;
        @(posedge mclk) disable iff (sys_rst)
        s_skew_tick |=> cursor == $past(cur_raw, 2);
    endproperty
    a_cur_skew: assert property (p_cur_skew) else $error("cursor skew wrong"); // R8

    property p_pen_cap;
        @(posedge mclk) disable iff (sys_rst)
        lp_pend_q && cc_fall |=> pen_q == $past(vaddr_q) && penfull_q;
    endproperty
    a_pen_cap: assert property (p_pen_cap) else $error("pen address not captured"); // R9

    property p_upd_inc;
        @(posedge mclk) disable iff (sys_rst)
        upd_evt |=> update_address == $past(upd_q) + 14'h0001 && updrdy_q;
    endproperty
    a_upd_inc: assert property (p_upd_inc) else $error("update address not stepped"); // R10 R11

    property p_rowcol;
        @(posedge mclk) disable iff (sys_rst)
        mode_q[MODE_ROWCOL] |=> vaddr_q[7:0] == $past(start_q[7:0] + hcnt_q);
    endproperty
    a_rowcol: assert property (p_rowcol) else $error("column not on low lines"); // R13

    property p_vbl_stat;
        @(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == IDX_STAT |=> reg_rdata[ST_VBLANK] == $past(vblank);
    endproperty
    a_vbl_stat: assert property (p_vbl_stat) else $error("retrace bit wrong"); // R16
endmodule

// ==== crc_far_model.sv ====
`timescale 1ns/1ps
module crc_far_model (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               run,
    input  wire logic               pen_fire,
    input  wire logic               host_sel,
    input  wire crc_pkg::crc_addr_t host_addr,
    input  wire crc_pkg::crc_addr_t display_addr,
    output logic                    character_clock,
    output logic                    light_pen_strobe,
    output crc_pkg::crc_addr_t      mem_addr
);
    import crc_pkg::*;
    logic [2:0] phase_q;
    logic [4:0] pen_cnt_q;
    // ==========================================
    // pin drivers
    // character clock of eight mclk, parked low while stopped
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end
    assign character_clock = phase_q[2];
    // pen pulse held long enough to pass the synchronizer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pen_cnt_q <= 5'h00;
        end else if (pen_fire) begin
            pen_cnt_q <= 5'h10;
        end else if (pen_cnt_q != 5'h00) begin
            pen_cnt_q <= pen_cnt_q - 5'h01;
        end
    end
    assign light_pen_strobe = (pen_cnt_q != 5'h00);
    // ==========================================
    // memory arbitration
    // host address overrides the display address when asked
    assign mem_addr = host_sel ? host_addr : display_addr;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import crc_pkg::*;
    // mclk cycles per field of the small raster
    localparam int FRAME = 16 * 2 * 2 * 8;
    typedef struct {
        crc_idx_t  idx;
        crc_byte_t wd;
        crc_byte_t exp;
    } crc_row_s;
    logic      mclk, sys_rst, reg_wr, reg_rd, run, pen_fire, host_sel;
    logic      de, cur, vs, irq, cc, lp, snap_irq;
    crc_idx_t  reg_addr;
    crc_byte_t reg_wdata, reg_rdata, q;
    crc_addr_t vaddr, upd, mem_addr, vaddr_cur, vaddr_de, exp_pen, snap_upd;
    crc_line_t lcnt;
    int        num_errors, checked, n_cur, n_vs, t_vs, t_de;
    crc_row_s  rows [6] = '{'{IDX_CURH, 8'hFF, 8'h3F}, '{IDX_CURL, 8'hA5, 8'hA5},
                            '{IDX_VDISP, 8'h55, 8'h00}, '{IDX_STL, 8'h77, 8'h00},
                            '{IDX_PENL, 8'h5A, 8'h00}, '{5'h17, 8'hFF, 8'h00}};
    // ==========================================
    // design and far side
    crc_core crc_core_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .character_clock(cc), .light_pen_strobe(lp), .display_memory_address_lines(vaddr),
        .row_scan_lines(lcnt), .update_address(upd), .display_enable(de), .cursor(cur),
        .vsync(vs), .irq(irq));
    crc_far_model crc_far_model_inst (.mclk(mclk), .sys_rst(sys_rst), .run(run),
        .pen_fire(pen_fire), .host_sel(host_sel), .host_addr(14'h0ABC), .display_addr(vaddr),
        .character_clock(cc), .light_pen_strobe(lp), .mem_addr(mem_addr));
    // clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ==========================================
    // tasks
    // one bus cycle, read data and side effects sampled after the edge
    task automatic bus(input logic w, input crc_idx_t a, input crc_byte_t d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
        snap_irq = irq;
        snap_upd = upd;
        @(posedge mclk);
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    // counts cursor and vsync pulses and vsync and enable high times over whole fields
    task automatic watch(input int frames);
        logic pc;
        logic pv;
        logic pd;
        pc = cur;
        pv = vs;
        pd = de;
        n_cur = 0;
        n_vs = 0;
        t_vs = 0;
        t_de = 0;
        repeat (frames * FRAME) begin
            @(posedge mclk);
            #1;
            if (cur && !pc) begin
                n_cur++;
                vaddr_cur = vaddr;
            end
            if (de && !pd) begin
                vaddr_de = vaddr;
            end
            n_vs += int'(vs && !pv);
            t_vs += int'(vs);
            t_de += int'(de);
            pc = cur;
            pv = vs;
            pd = de;
        end
        @(posedge mclk);
    endtask
    task automatic cur_case(input crc_byte_t cst, input crc_byte_t mode, input int frames,
                            input int edges, input crc_addr_t at);
        bus(1'b1, IDX_MODE, mode);
        bus(1'b1, IDX_CST, cst);
        watch(frames);
        check("cursor_pulses", n_cur, edges);
        if (edges > 0) begin
            check("cursor_address", vaddr_cur, at);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end
    // ==========================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        run = 1'b0;
        pen_fire = 1'b0;
        host_sel = 1'b0;
        num_errors = 0;
        checked = 0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // write then read back each table row
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 8'h00);
            check("reg_read", q, rows[i].exp);
        end
        end_test("register table");
        // transparent update address, dummy location and interrupt
        bus(1'b1, IDX_IMSK, 8'h00);
        bus(1'b1, IDX_MODE, 8'h08);
        bus(1'b1, IDX_UPDH, 8'h3F);
        bus(1'b1, IDX_UPDL, 8'hFF);
        check("update_address", snap_upd, 14'h3FFF);
        bus(1'b1, IDX_DUMMY, 8'h55);
        check("update_wrap", snap_upd, 14'h0000);
        bus(1'b0, IDX_DUMMY, 8'h00);
        check("update_read", snap_upd, 14'h0001);
        check("dummy_data", q, 8'h00);
        check("irq_masked", snap_irq, 1'b0);
        bus(1'b0, IDX_STAT, 8'h00);
        check("update_ready", q[ST_UPD], 1'b1);
        bus(1'b1, IDX_IMSK, 8'h01);
        check("irq_set", snap_irq, 1'b1);
        bus(1'b1, IDX_IST, 8'h01);
        check("irq_clear", snap_irq, 1'b0);
        bus(1'b1, IDX_UPDL, 8'h01);
        bus(1'b0, IDX_STAT, 8'h00);
        check("update_cleared", q[ST_UPD], 1'b0);
        bus(1'b1, IDX_MODE, 8'h00);
        bus(1'b1, IDX_DUMMY, 8'h00);
        check("dummy_idle", snap_upd, 14'h0001);
        end_test("update address");
        // small raster: 2 rows of 2 lines, 1 displayed, vsync in row 1
        bus(1'b1, IDX_VTOT, 8'h01);
        bus(1'b1, IDX_VDISP, 8'h01);
        bus(1'b1, IDX_VSYNC, 8'h01);
        bus(1'b1, IDX_SCAN, 8'h01);
        bus(1'b1, IDX_CEND, 8'h01);
        bus(1'b1, IDX_STH, 8'h05);
        bus(1'b1, IDX_STL, 8'h10);
        bus(1'b1, IDX_CURH, 8'h05);
        bus(1'b1, IDX_CURL, 8'h12);
        run <= 1'b1;
        repeat (FRAME) @(posedge mclk);
        cur_case(8'h00, 8'h00, 1, 2, 14'h0512);
        check("enable_address", vaddr_de, 14'h0510);
        check("vsync_pulses", n_vs, 1);
        check("vsync_time", t_vs, 16 * 2 * 8);
        check("enable_time", t_de, 10 * 2 * 8);
        cur_case(8'h01, 8'h00, 1, 1, 14'h0512);
        cur_case(8'h20, 8'h00, 1, 0, 14'h0000);
        cur_case(8'h40, 8'h00, 32, 32, 14'h0512);
        cur_case(8'h60, 8'h00, 32, 32, 14'h0512);
        cur_case(8'h00, 8'h20, 1, 2, 14'h0513);
        cur_case(8'h00, 8'h30, 1, 2, 14'h0513);
        check("enable_skew", vaddr_de, 14'h0511);
        check("enable_skew_time", t_de, 10 * 2 * 8);
        bus(1'b1, IDX_CURH, 8'h06);
        cur_case(8'h00, 8'h00, 1, 0, 14'h0000);
        cur_case(8'h00, 8'h04, 1, 2, 14'h0612);
        end_test("raster and cursor");
        // vertical retrace status
        while (!vs) @(posedge mclk);
        bus(1'b0, IDX_STAT, 8'h00);
        check("vblank_on", q[ST_VBLANK], 1'b1);
        while (!de) @(posedge mclk);
        bus(1'b0, IDX_STAT, 8'h00);
        check("vblank_off", q[ST_VBLANK], 1'b0);
        // light pen capture on the next falling character edge
        @(negedge cc);
        @(posedge mclk);
        pen_fire <= 1'b1;
        @(posedge mclk);
        pen_fire <= 1'b0;
        @(negedge cc);
        repeat (2) @(posedge mclk);
        exp_pen = vaddr;
        repeat (20) @(posedge mclk);
        bus(1'b0, IDX_STAT, 8'h00);
        check("pen_full", q[ST_PEN], 1'b1);
        bus(1'b0, IDX_PENH, 8'h00);
        check("pen_high", q, {2'b00, exp_pen[13:8]});
        bus(1'b0, IDX_PENL, 8'h00);
        check("pen_low", q, exp_pen[7:0]);
        bus(1'b0, IDX_STAT, 8'h00);
        check("pen_cleared", q[ST_PEN], 1'b0);
        host_sel <= 1'b1;
        @(posedge mclk);
        check("host_override", mem_addr, 14'h0ABC);
        end_test("light pen and retrace");
        // second reset in mid-run
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("reset_vaddr", vaddr, 14'h0000);
        check("reset_lcnt", lcnt, 5'h00);
        check("reset_upd", upd, 14'h0000);
        check("reset_irq", irq, 1'b0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, IDX_CURL, 8'h00);
        check("reset_cursor", q, 8'h00);
        end_test("reset");
        report_and_stop();
    end
endmodule
